// ==== hdl/host_port_pkg.sv ====
// Constants and carrier types for the parallel host port controller.
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 10;
    localparam int NUM_XCVR = 4;
    localparam int LOW_ADDR_W = 7;
    localparam int TOP_ADDR_POS = 7;
    localparam int UPPER_ADDR_LSB = 8;
    // Strobe timing, given in ns and rounded up to cycles of clk_in.
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 80;
    localparam int HOLD_NS = 20;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC =
        (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_NS = 100;
    localparam int RESET_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [3:0] SEL_IDLE = 4'hf;

    typedef struct packed {
        logic write;
        logic [1:0] xcvr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic shared_bus_select;
        logic bus_style_strap;
        logic single_select;
    } port_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_LATCH = 3'b010,
        ST_SETUP = 3'b011,
        ST_STROBE = 3'b100,
        ST_HOLD = 3'b101,
        ST_RESET = 3'b110
    } port_state_t;
endpackage

// ==== hdl/phase_timer.sv ====
// Down counter that times each phase of a bus cycle.
`timescale 1ns/1ps
module phase_timer
    import host_port_pkg::*;
#(
    parameter int W = CNT_W
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [W-1:0] count_in,
    output logic done_out
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            cnt_q <= '0;
        else if (load_in)
            cnt_q <= count_in;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign done_out = (cnt_q == W'(1)) || (cnt_q == '0);
endmodule // phase_timer

// ==== hdl/host_port_ctrl.sv ====
// Host-side controller that drives the framer's parallel control port.
`timescale 1ns/1ps
module host_port_ctrl
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire port_mode_t mode_in,
    input wire logic req_valid_in,
    input wire host_req_t req_in,
    input wire logic dev_reset_req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [DATA_W-1:0] rsp_data_out,
    input wire logic [DATA_W-1:0] addr_data_bus_in,
    output logic [DATA_W-1:0] addr_data_bus_out,
    output logic addr_data_bus_oe_out,
    output logic [LOW_ADDR_W-1:0] low_addr_bits_out,
    output logic top_addr_bit_out,
    output logic [1:0] upper_addr_bits_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out,
    output logic xcvr1_select_n_out,
    output logic xcvr2_select_n_out,
    output logic xcvr3_select_n_out,
    output logic xcvr4_select_n_out,
    output logic float_and_reset_pin_out,
    input wire logic host_alert_n_in,
    output logic alert_out
);
    port_state_t state_q;
    port_state_t state_d;
    host_req_t req_q;
    host_req_t req_d;
    // Pins follow the request being taken, never the one before it.
    assign req_d = (state_q == ST_IDLE && req_valid_in && !dev_reset_req_in)
        ? req_in : req_q;
    logic timer_load;
    logic [CNT_W-1:0] timer_count;
    logic timer_done;
    logic [NUM_XCVR-1:0] sel_n;

    phase_timer #(.W(CNT_W)) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .load_in(timer_load),
        .count_in(timer_count),
        .done_out(timer_done)
    );

    always_comb
    begin
        state_d = state_q;
        timer_load = 1'b0;
        timer_count = CNT_ONE;
        case (state_q)
            ST_IDLE:
            begin
                if (dev_reset_req_in)
                begin
                    state_d = ST_RESET;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(RESET_CYC);
                end
                else if (req_valid_in)
                begin
                    // Multiplexed cycles first put the address on the bus.
                    state_d = mode_in.shared_bus_select ? ST_ADDR : ST_SETUP;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(SETUP_CYC);
                end
            end
            ST_ADDR:
                if (timer_done)
                begin
                    state_d = ST_LATCH;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(HOLD_CYC);
                end
            ST_LATCH:
                if (timer_done)
                begin
                    state_d = ST_SETUP;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(SETUP_CYC);
                end
            ST_SETUP:
                if (timer_done)
                begin
                    state_d = ST_STROBE;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(STROBE_CYC);
                end
            ST_STROBE:
                if (timer_done)
                begin
                    state_d = ST_HOLD;
                    timer_load = 1'b1;
                    timer_count = CNT_W'(HOLD_CYC);
                end
            ST_HOLD:
                if (timer_done)
                    state_d = ST_IDLE;
            ST_RESET:
                if (timer_done)
                    state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            req_q <= '0;
        else
            req_q <= req_d;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            req_ready_out <= 1'b0;
        else
            req_ready_out <= (state_d == ST_IDLE);
    end

    // The pulse on the reset pin gives the device its rising edge; low
    // otherwise keeps the device's pins out of high impedance.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            float_and_reset_pin_out <= 1'b0;
        else
            float_and_reset_pin_out <= (state_d == ST_RESET);
    end

    // Address pins: separate bus drives all address pins, multiplexed
    // bus ties the low bits low and raises the capture strobe.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            low_addr_bits_out <= '0;
            top_addr_bit_out <= 1'b0;
            upper_addr_bits_out <= '0;
        end
        else if (mode_in.shared_bus_select)
        begin
            low_addr_bits_out <= '0;
            top_addr_bit_out <= (state_d == ST_LATCH);
            upper_addr_bits_out <=
                req_d.addr[ADDR_W-1:UPPER_ADDR_LSB];
        end
        else
        begin
            low_addr_bits_out <= req_d.addr[LOW_ADDR_W-1:0];
            top_addr_bit_out <= req_d.addr[TOP_ADDR_POS];
            upper_addr_bits_out <=
                req_d.addr[ADDR_W-1:UPPER_ADDR_LSB];
        end
    end

    // Data pins: address phase in multiplexed mode, write data while
    // writing, released during reads so the device can drive them.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            addr_data_bus_out <= DATA_ZERO;
            addr_data_bus_oe_out <= 1'b0;
        end
        else if (state_d == ST_ADDR || state_d == ST_LATCH)
        begin
            addr_data_bus_out <= req_d.addr[DATA_W-1:0];
            addr_data_bus_oe_out <= 1'b1;
        end
        else if (req_d.write && (state_d == ST_SETUP ||
                 state_d == ST_STROBE || state_d == ST_HOLD))
        begin
            addr_data_bus_out <= req_d.wdata;
            addr_data_bus_oe_out <= 1'b1;
        end
        else
        begin
            addr_data_bus_out <= DATA_ZERO;
            addr_data_bus_oe_out <= 1'b0;
        end
    end

    // Strobe pins.  In strobe-direction style the write pin carries the
    // direction and the read pin the data strobe.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            read_strobe_n_out <= 1'b1;
            write_strobe_n_out <= 1'b1;
        end
        else if (mode_in.bus_style_strap)
        begin
            write_strobe_n_out <= !req_d.write;
            // The data strobe is active high on the separate bus.
            if (mode_in.shared_bus_select)
                read_strobe_n_out <= (state_d != ST_STROBE);
            else
                read_strobe_n_out <= (state_d == ST_STROBE);
        end
        else
        begin
            read_strobe_n_out <=
                !(state_d == ST_STROBE && !req_d.write);
            write_strobe_n_out <=
                !(state_d == ST_STROBE && req_d.write);
        end
    end

    // Selects stay low from the address phase (setup on the separate bus) through hold so the read data window
    // is framed by select and strobe together.
    always_comb
    begin
        sel_n = SEL_IDLE;
        if (state_d == ST_SETUP || state_d == ST_STROBE ||
            state_d == ST_HOLD || state_d == ST_ADDR || state_d == ST_LATCH)
        begin
            if (mode_in.single_select)
                sel_n[0] = 1'b0;
            else
                sel_n[req_d.xcvr] = 1'b0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            xcvr1_select_n_out <= 1'b1;
            xcvr2_select_n_out <= 1'b1;
            xcvr3_select_n_out <= 1'b1;
            xcvr4_select_n_out <= 1'b1;
        end
        else
        begin
            xcvr1_select_n_out <= sel_n[0];
            xcvr2_select_n_out <= sel_n[1];
            xcvr3_select_n_out <= sel_n[2];
            xcvr4_select_n_out <= sel_n[3];
        end
    end

    // Read data is sampled on the last strobe cycle, before release.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rsp_valid_out <= 1'b0;
            rsp_data_out <= DATA_ZERO;
        end
        else
        begin
            rsp_valid_out <= (state_q == ST_STROBE) && timer_done &&
                             !req_q.write;
            if (state_q == ST_STROBE && timer_done && !req_q.write)
                rsp_data_out <= addr_data_bus_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            alert_out <= 1'b0;
        else
            alert_out <= !host_alert_n_in;
    end
endmodule // host_port_ctrl

// ==== test/host_port_ctrl_properties.sv ====
// Port-level assertions for the parallel host port controller.
`timescale 1ns/1ps
module host_port_ctrl_checker
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire port_mode_t mode_in,
    input wire logic [DATA_W-1:0] addr_data_bus_out,
    input wire logic addr_data_bus_oe_out,
    input wire logic [LOW_ADDR_W-1:0] low_addr_bits_out,
    input wire logic top_addr_bit_out,
    input wire logic read_strobe_n_out,
    input wire logic write_strobe_n_out,
    input wire logic xcvr1_select_n_out,
    input wire logic xcvr2_select_n_out,
    input wire logic xcvr3_select_n_out,
    input wire logic xcvr4_select_n_out,
    input wire logic float_and_reset_pin_out,
    input wire logic host_alert_n_in,
    input wire logic alert_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [3:0] sel_n;
    logic sep_strobes;
    assign sel_n = {xcvr4_select_n_out, xcvr3_select_n_out,
        xcvr2_select_n_out, xcvr1_select_n_out};
    assign sep_strobes = !mode_in.bus_style_strap;
    a_reset_pulse_len: assert property (
        $rose(float_and_reset_pin_out) |-> float_and_reset_pin_out[*8]
        ##[1:3] !float_and_reset_pin_out) else $error("reset pulse");
    a_float_port_quiet: assert property (
        float_and_reset_pin_out |-> sel_n == SEL_IDLE
        && !addr_data_bus_oe_out) else $error("access in float");
    a_single_select: assert property (
        $onehot0(~sel_n)) else $error("two selects low");
    a_mux_addr_low: assert property (
        mode_in.shared_bus_select && sel_n != SEL_IDLE
        |-> low_addr_bits_out == 7'h00) else $error("low addr");
    a_capture_stable: assert property (
        mode_in.shared_bus_select && $rose(top_addr_bit_out)
        |-> addr_data_bus_oe_out && $stable(addr_data_bus_out))
        else $error("capture edge");
    a_write_width: assert property (
        sep_strobes && $fell(write_strobe_n_out) |-> !write_strobe_n_out[*8]
        ##1 write_strobe_n_out) else $error("write width");
    a_read_released: assert property (
        sep_strobes && $stable(mode_in) && !read_strobe_n_out
        |-> !addr_data_bus_oe_out
        && sel_n != SEL_IDLE) else $error("read drive");
    a_alert_follow: assert property (
        1'b1 |=> alert_out == !$past(host_alert_n_in))
        else $error("alert lag");
    c_write: cover property (sep_strobes && $fell(write_strobe_n_out));
    c_capture: cover property (mode_in.shared_bus_select
        && $rose(top_addr_bit_out));
    c_float: cover property ($rose(float_and_reset_pin_out));
endmodule // host_port_ctrl_checker

bind host_port_ctrl host_port_ctrl_checker host_port_ctrl_checker_inst (
    .clk_in, .rst_in, .mode_in, .addr_data_bus_out, .addr_data_bus_oe_out,
    .low_addr_bits_out, .top_addr_bit_out, .read_strobe_n_out,
    .write_strobe_n_out, .xcvr1_select_n_out, .xcvr2_select_n_out,
    .xcvr3_select_n_out, .xcvr4_select_n_out, .float_and_reset_pin_out,
    .host_alert_n_in, .alert_out);

// ==== test/framer_port_model.sv ====
// Behavioural model of the framer's parallel control port.
`timescale 1ns/1ps
module framer_port_model
    import host_port_pkg::*;
(
    input wire logic clk_in,
    input wire port_mode_t mode_in,
    input wire logic [DATA_W-1:0] bus_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [3:0] sel_n_in,
    input wire logic float_in,
    input wire logic alert_in,
    output logic drive_out,
    output logic [DATA_W-1:0] data_out,
    output logic alert_n_out
);
    logic [DATA_W-1:0] mem_q [4096];
    logic [ADDR_W-1:0] lat_q, a;
    logic top_q, float_q, sel, ds, wr;
    logic [1:0] x;
    assign sel = mode_in.single_select ? !sel_n_in[0]
        : sel_n_in != 4'hf;
    assign x = !sel_n_in[1] ? 2'd1 : !sel_n_in[2] ? 2'd2
        : !sel_n_in[3] ? 2'd3 : 2'd0;
    assign ds = mode_in.shared_bus_select ? !rd_n_in : rd_n_in;
    assign drive_out = sel && !float_in && (mode_in.bus_style_strap ?
        ds && wr_n_in : !rd_n_in);
    assign wr = sel && !float_in && (mode_in.bus_style_strap ?
        ds && !wr_n_in : !wr_n_in);
    // Low address pins are ignored when the bus is shared.
    assign a = mode_in.shared_bus_select ? lat_q : addr_in;
    assign data_out = mem_q[{x, mode_in.single_select ? a
        : {2'b00, a[7:0]}}];
    assign alert_n_out = !alert_in;
    always @(posedge clk_in)
    begin
        top_q <= addr_in[7];
        float_q <= float_in;
        if (mode_in.shared_bus_select && addr_in[7] && !top_q)
            lat_q <= {addr_in[9:8], bus_in};
        if (wr)
            mem_q[{x, mode_in.single_select ? a : {2'b00, a[7:0]}}] <= bus_in;
        if (float_in && !float_q)
            foreach (mem_q[i])
                mem_q[i] <= 8'h00;
    end
endmodule // framer_port_model

// ==== test/parallel_host_control_port_tb_top.sv ====
// Self-checking bench for the parallel host port controller.
`timescale 1ns/1ps
module parallel_host_control_port_tb_top;
    import host_port_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    port_mode_t mode_in;
    host_req_t req_in;
    logic req_valid_in, dev_reset_req_in, alert_req, dev_drv;
    logic req_ready_out, rsp_valid_out, addr_data_bus_oe_out, top_addr_bit_out;
    logic read_strobe_n_out, write_strobe_n_out, float_and_reset_pin_out;
    logic xcvr1_select_n_out, xcvr2_select_n_out, alert_out, host_alert_n_in;
    logic xcvr3_select_n_out, xcvr4_select_n_out;
    logic [7:0] rsp_data_out, addr_data_bus_out, dev_data, bus;
    logic [7:0] bus_last = 8'h00;
    logic [6:0] low_addr_bits_out;
    logic [1:0] upper_addr_bits_out;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    always #5 clk_in = ~clk_in;
    // Nobody driving: show a changing pattern so stale data cannot pass.
    assign bus = addr_data_bus_oe_out ? addr_data_bus_out
        : dev_drv ? dev_data : ~bus_last;
    always @(posedge clk_in)
    begin
        bus_last <= bus;
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end
    host_port_ctrl host_port_ctrl_inst (.clk_in, .rst_in, .mode_in,
        .req_valid_in, .req_in, .dev_reset_req_in, .req_ready_out,
        .rsp_valid_out, .rsp_data_out, .addr_data_bus_in(bus),
        .addr_data_bus_out, .addr_data_bus_oe_out, .low_addr_bits_out,
        .top_addr_bit_out, .upper_addr_bits_out, .read_strobe_n_out,
        .write_strobe_n_out, .xcvr1_select_n_out, .xcvr2_select_n_out,
        .xcvr3_select_n_out, .xcvr4_select_n_out, .float_and_reset_pin_out,
        .host_alert_n_in, .alert_out);
    framer_port_model framer_port_model_inst (.clk_in, .mode_in,
        .bus_in(bus), .addr_in({upper_addr_bits_out, top_addr_bit_out,
        low_addr_bits_out}), .rd_n_in(read_strobe_n_out),
        .wr_n_in(write_strobe_n_out), .sel_n_in({xcvr4_select_n_out,
        xcvr3_select_n_out, xcvr2_select_n_out, xcvr1_select_n_out}),
        .float_in(float_and_reset_pin_out), .alert_in(alert_req),
        .drive_out(dev_drv), .data_out(dev_data),
        .alert_n_out(host_alert_n_in));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (req_ready_out !== 1'b1 && n++ < 200)
        begin
            @(posedge clk_in);
            #1;
        end
        if (n > 200)
            mismatches++;
    endtask
    task automatic acc(input logic w, input logic [1:0] x,
        input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        wait_ready();
        req_in = {w, x, a, d};
        req_valid_in = 1'b1;
        @(posedge clk_in);
        #1;
        req_valid_in = 1'b0;
        q = 8'h00;
        while (!w && rsp_valid_out !== 1'b1 && n++ < 200)
        begin
            @(posedge clk_in);
            #1;
        end
        if (n > 200)
            mismatches++;
        if (!w)
            q = rsp_data_out;
    endtask
    task automatic dev_rst(output int cnt);
        int n;
        n = 0;
        cnt = 0;
        wait_ready();
        dev_reset_req_in = 1'b1;
        @(posedge clk_in);
        #1;
        dev_reset_req_in = 1'b0;
        while (float_and_reset_pin_out !== 1'b1 && n++ < 20)
        begin
            @(posedge clk_in);
            #1;
        end
        if (n > 20)
            mismatches++;
        while (float_and_reset_pin_out === 1'b1 && cnt < 50)
        begin
            cnt++;
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic t_modes(input logic single);
        logic [7:0] q;
        logic [9:0] a;
        for (int i = 0; i < 4; i++)
        begin
            wait_ready();
            mode_in = {i[1], i[0], single};
            a = single ? 10'h2c7 : {2'b00, 8'h90 + 8'(i)};
            acc(1'b1, 2'(i), a, 8'h3c + 8'(i), q);
            acc(1'b0, 2'(i), a, 8'h00, q);
            chk(q, 8'h3c + 8'(i));
            acc(1'b0, 2'(i + 1), a ^ 10'h200, 8'h00, q);
            chk(q, 8'h00);
        end
    endtask
    task automatic t_reset();
        logic [7:0] q;
        int cnt;
        dev_rst(cnt);
        chk(8'(cnt), 8'(RESET_CYC));
        mode_in = '0;
        acc(1'b0, 2'd0, 10'h090, 8'h00, q);
        chk(q, 8'h00);
    endtask
    task automatic t_alert();
        alert_req = 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk({7'h00, alert_out}, 8'h01);
        alert_req = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        chk({7'h00, alert_out}, 8'h00);
    endtask
    task automatic final_report();
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        int cnt;
        mode_in = '0;
        req_in = '0;
        req_valid_in = 1'b0;
        dev_reset_req_in = 1'b0;
        alert_req = 1'b0;
        repeat (12) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        dev_rst(cnt);
        t_modes(1'b0);
        t_modes(1'b1);
        t_reset();
        t_alert();
        final_report();
    end
endmodule // parallel_host_control_port_tb_top
